// *** hw/nwu_pkg.sv ***
// Constants, types and helpers shared by the nested translation upper walker.
// Operation
// R01 - Index only with guest address bits 47:0.
// R02 - Walk spans four levels, at most four fetches.
// R03 - Top table base from root pointer 51:12.
// R04 - Top entry address: root base plus bits 47:39.
// R05 - Top entry governs one 512-GByte region.
// R06 - Entry bits 0,1,2 grant read, write, fetch.
// R07 - Top entry 7:3, 51:N reserved; others ignored.
// R08 - Top entry (N-1):12 gives next table base.
// R09 - Third entry address: base plus bits 38:30.
// R10 - Third entry bit 7 selects page or directory.
// R11 - Page address: entry 51:30, guest 29:0.
// R12 - Page passes memory type and ignore flag.
// R13 - Page entry 29:12 reserved; base from (N-1):30.
// R14 - Software checks support before mapping big pages.
// R15 - Directory entry address: base plus bits 29:21.
// R16 - Directory pointer 7:3 reserved; base (N-1):12.
// R17 - Directory entry covers 2-MByte region, handed on.
// R18 - Wide guest address faults; wide root load faults.
// R19 - Entry with bits 2:0 zero is not present.
// R20 - Misconfiguration outranks violation.
// R21 - Every visited entry must grant the access.
package nwu_pkg;
  // Implemented physical-address width N; a plain default.
  localparam int PA_W = 48;
  localparam int PERM_W = 3;
  localparam int IDX_W = 9;
  localparam int ENT_SH = 3;
  localparam int TOP_LO = 39;
  localparam int THIRD_LO = 30;
  localparam int DIR_LO = 21;
  localparam int GPA_MSB = 47;
  localparam int PS_BIT = 7;
  localparam int MT_LO = 3;
  localparam int IPAT_BIT = 6;
  localparam int LVL_W = 3;
  localparam int REG_W = 32;
  localparam int REGION_W = GPA_MSB - DIR_LO + 1;
  // Level numbers; zero means no failing level.
  localparam logic [LVL_W-1:0] LVL_NONE = 3'h0;
  localparam logic [LVL_W-1:0] LVL_DIR = 3'h2;
  localparam logic [LVL_W-1:0] LVL_THIRD = 3'h3;
  localparam logic [LVL_W-1:0] LVL_TOP = 3'h4;
  localparam logic [LVL_W-1:0] LVL_UPPER_MAX = 3'h2;
  // Address and reserved masks.
  localparam logic [63:0] BASE_MASK = 64'h000F_FFFF_FFFF_F000;
  localparam logic [63:0] GB_MASK = 64'h000F_FFFF_C000_0000;
  localparam logic [63:0] GB_OFS = 64'h0000_0000_3FFF_FFFF;
  localparam logic [63:0] LOW_RSVD = 64'h0000_0000_0000_00F8;
  localparam logic [63:0] GB_RSVD = 64'h0000_0000_3FFF_F000;
  localparam logic [63:0] ADDR_TOP0 = 64'hFFF0_0000_0000_0000;
  localparam logic [63:0] WIDE_MASK = 64'hFFFF_0000_0000_0000;
  // Register map, byte addresses on an 8-bit port.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ROOT_LO = 8'h04;
  localparam logic [7:0] REG_ROOT_HI = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_WALKS = 8'h10;
  localparam int CTRL_EN = 0;
  localparam int CTRL_GB = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int ST_BUSY = 0;
  localparam int ST_VIOL = 1;
  localparam int ST_MISC = 2;
  localparam int ST_PF = 3;
  localparam int ST_GP = 4;
  localparam int ST_LVL = 8;
  // Walker states.
  typedef enum logic [1:0] {W_IDLE, W_TOP, W_THIRD} nwu_state_t;

  // Entry fetch address: table base 51:12, index in 11:3, rest zero.
  function automatic logic [63:0] nwu_ent_addr(input logic [63:0] base, input logic [IDX_W-1:0] idx);
    nwu_ent_addr = (base & BASE_MASK) | (64'(idx) << ENT_SH);
  endfunction
endpackage

// *** hw/nwu_cfg_if.sv ***
// Configuration and status carrier between register file and walker.
`timescale 1ns/1ps
`default_nettype none
interface nwu_cfg_if;
  import nwu_pkg::*;
  logic enable;        // Walker accepts requests.
  logic gb_en;         // 1-GByte pages supported.
  logic [63:0] root;   // Nested root pointer.
  logic [REG_W-1:0] status; // Packed walker status.
  logic done;          // One-cycle pulse per finished walk.
  modport regs(output enable, gb_en, root, input status, done);
  modport walker(input enable, gb_en, root, output status, done);
endinterface
`default_nettype wire

// *** hw/nwu_entry_chk.sv ***
// Decodes one fetched paging-structure entry: presence, page bit, reserved bits.
`timescale 1ns/1ps
`default_nettype none
module nwu_entry_chk import nwu_pkg::*; #(
  parameter int PAW = PA_W
) (
  // Entry and its level.
  input wire logic [63:0] entry_in,
  input wire logic top_in,
  // Decode results.
  output logic present_out,
  output logic page_out,
  output logic rsvd_out
);
  // Bits 51:N hold no address on this part.
  logic [63:0] hi_rsvd;
  assign hi_rsvd = BASE_MASK & ~((64'h1 << PAW) - 64'h1);
  // R19 presence test
  assign present_out = |entry_in[PERM_W-1:0];
  // R10 page select
  assign page_out = !top_in && entry_in[PS_BIT];
  // Reserved masks differ for page entries and pointer entries.
  always_comb begin
    if (page_out) begin
      // R13 page reserved bits
      rsvd_out = |(entry_in & (hi_rsvd | GB_RSVD));
    end else begin
      // R07 R16 pointer reserved bits
      rsvd_out = |(entry_in & (hi_rsvd | LOW_RSVD));
    end
  end
endmodule
`default_nettype wire

// *** hw/nwu_regs.sv ***
// Register file of the walker on a plain strobe port.
`timescale 1ns/1ps
`default_nettype none
module nwu_regs import nwu_pkg::*; (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register port.
  input wire logic [7:0] addr_in,
  input wire logic [REG_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [REG_W-1:0] rdata_out,
  // Walker side.
  nwu_cfg_if.regs cfg
);
  typedef struct packed {
    logic [1:0] ctrl;
    logic [REG_W-1:0] root_lo;
    logic [REG_W-1:0] root_hi;
    logic [REG_W-1:0] walks;
    logic [REG_W-1:0] rdata;
  } nwu_regs_t;
  nwu_regs_t s;
  nwu_regs_t next_s;

  // Decode writes and reads; read data stand for one cycle only.
  always_comb begin
    next_s = s;
    next_s.rdata = '0;
    if (cfg.done) begin
      next_s.walks = s.walks + 32'h1;
    end
    if (wr_in) begin
      if (addr_in == REG_CTRL) begin
        next_s.ctrl = wdata_in[1:0];
      end else if (addr_in == REG_ROOT_LO) begin
        next_s.root_lo = wdata_in;
      end else if (addr_in == REG_ROOT_HI) begin
        next_s.root_hi = wdata_in;
      end
    end
    if (rd_in) begin
      if (addr_in == REG_CTRL) begin
        next_s.rdata = {30'h0, s.ctrl};
      end else if (addr_in == REG_ROOT_LO) begin
        next_s.rdata = s.root_lo;
      end else if (addr_in == REG_ROOT_HI) begin
        next_s.rdata = s.root_hi;
      end else if (addr_in == REG_STATUS) begin
        next_s.rdata = cfg.status;
      end else if (addr_in == REG_WALKS) begin
        next_s.rdata = s.walks;
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out = s.rdata;
  assign cfg.enable = s.ctrl[CTRL_EN];
  assign cfg.gb_en = s.ctrl[CTRL_GB];
  assign cfg.root = {s.root_hi, s.root_lo};
endmodule
`default_nettype wire

// *** hw/nwu_walker.sv ***
// Top of the nested translation walker: top-level and third-level steps.
`timescale 1ns/1ps
`default_nettype none
module nwu_walker import nwu_pkg::*; (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register port.
  input wire logic [7:0] reg_addr_in,
  input wire logic [REG_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [REG_W-1:0] reg_rdata_out,
  // Translation request.
  input wire logic req_valid_in,
  input wire logic [63:0] req_gpa_in,
  input wire logic [PERM_W-1:0] req_acc_in,
  output logic req_ready_out,
  // Guest root register load check.
  input wire logic groot_load_in,
  input wire logic [63:0] groot_val_in,
  output logic groot_gp_out,
  // Entry fetch from the memory system.
  output logic mem_req_out,
  output logic [63:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [63:0] mem_data_in,
  // Walk result.
  output logic res_valid_out,
  output logic res_page_out,
  output logic [63:0] res_pa_out,
  output logic [2:0] res_mtype_out,
  output logic res_ipat_out,
  output logic [63:0] res_dir_addr_out,
  output logic [REGION_W-1:0] res_region_out,
  output logic [PERM_W-1:0] res_perm_out,
  output logic res_viol_out,
  output logic res_misconf_out,
  output logic res_pf_out,
  output logic [LVL_W-1:0] res_fail_lvl_out,
  output logic [LVL_W-1:0] res_levels_out
);
  // Whole walker state; all outputs but reg_rdata_out are read straight from it.
  typedef struct packed {
    nwu_state_t st;
    logic [63:0] gpa;
    logic [PERM_W-1:0] acc;
    logic ready;
    logic gp;
    logic mreq;
    logic [63:0] maddr;
    logic rvalid;
    logic page;
    logic [63:0] pa;
    logic [2:0] mt;
    logic ipat;
    logic [63:0] daddr;
    logic [REGION_W-1:0] region;
    logic [PERM_W-1:0] perm;
    logic viol;
    logic misc;
    logic pf;
    logic [LVL_W-1:0] fail;
    logic [LVL_W-1:0] lev;
  } nwu_walk_t;
  nwu_walk_t s;
  nwu_walk_t next_s;

  nwu_cfg_if cfg();
  logic ent_present;
  logic ent_page;
  logic ent_rsvd;
  logic take;
  logic [PERM_W-1:0] new_perm;
  logic [LVL_W-1:0] new_fail;

  // Software-facing registers.
  nwu_regs u_regs (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .addr_in(reg_addr_in),
    .wdata_in(reg_wdata_in),
    .wr_in(reg_wr_in),
    .rd_in(reg_rd_in),
    .rdata_out(reg_rdata_out),
    .cfg(cfg)
  );

  // Decoder for whichever entry is arriving now.
  nwu_entry_chk #(.PAW(PA_W)) u_chk (
    .entry_in(mem_data_in),
    .top_in(s.st == W_TOP),
    .present_out(ent_present),
    .page_out(ent_page),
    .rsvd_out(ent_rsvd)
  );

  // Status word for software; walk results hold until the next walk is taken, the root-load fault bit for one cycle only.
  assign cfg.done = s.rvalid;
  assign cfg.status = (REG_W'(s.st != W_IDLE) << ST_BUSY) | (REG_W'(s.viol) << ST_VIOL)
    | (REG_W'(s.misc) << ST_MISC) | (REG_W'(s.pf) << ST_PF) | (REG_W'(s.gp) << ST_GP)
    | (REG_W'(s.fail) << ST_LVL);

  // A request is taken only while idle and enabled.
  assign take = req_valid_in && s.ready;
  // R06 R21 permissions accumulate
  assign new_perm = s.perm & mem_data_in[PERM_W-1:0];
  // The first level that withholds a requested right is remembered.
  always_comb begin
    new_fail = s.fail;
    if ((s.fail == LVL_NONE) && ((s.acc & ~mem_data_in[PERM_W-1:0]) != '0)) begin
      new_fail = (s.st == W_TOP) ? LVL_TOP : LVL_THIRD;
    end
  end

  // Walk sequencing: take, fetch top entry, fetch third entry, report.
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.gp = 1'b0;
    // R18 wide root load
    if (groot_load_in && ((groot_val_in & WIDE_MASK) != '0)) begin
      next_s.gp = 1'b1;
    end
    case (s.st)
      W_IDLE: begin
        if (take) begin
          next_s.gpa = req_gpa_in;
          next_s.acc = req_acc_in;
          next_s.perm = '1;
          next_s.fail = LVL_NONE;
          next_s.lev = '0;
          next_s.viol = 1'b0;
          next_s.misc = 1'b0;
          next_s.pf = 1'b0;
          next_s.page = 1'b0;
          if ((req_gpa_in & WIDE_MASK) != '0) begin
            // R18 wide guest address
            next_s.pf = 1'b1;
            next_s.rvalid = 1'b1;
          end else begin
            // R01 R03 R04 R05 top entry address
            next_s.maddr = nwu_ent_addr(cfg.root, req_gpa_in[GPA_MSB:TOP_LO]);
            next_s.mreq = 1'b1;
            next_s.st = W_TOP;
          end
        end
      end
      W_TOP: begin
        if (mem_ack_in) begin
          // R02 count fetched entries
          next_s.lev = s.lev + 3'h1;
          if (!ent_present) begin
            // R19 not present ends walk
            next_s.viol = 1'b1;
            next_s.fail = LVL_TOP;
            next_s.perm = '0;
            next_s.mreq = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.st = W_IDLE;
          end else if (ent_rsvd) begin
            // R20 misconfiguration wins
            next_s.misc = 1'b1;
            next_s.fail = LVL_TOP;
            next_s.mreq = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.st = W_IDLE;
          end else begin
            // R08 R09 third entry address
            next_s.perm = new_perm;
            next_s.fail = new_fail;
            next_s.maddr = nwu_ent_addr(mem_data_in, s.gpa[TOP_LO-1:THIRD_LO]);
            next_s.st = W_THIRD;
          end
        end
      end
      W_THIRD: begin
        if (mem_ack_in) begin
          next_s.lev = s.lev + 3'h1;
          next_s.mreq = 1'b0;
          next_s.rvalid = 1'b1;
          next_s.st = W_IDLE;
          next_s.page = ent_page;
          if (!ent_present) begin
            // R19 not present ends walk
            next_s.viol = 1'b1;
            next_s.perm = '0;
            next_s.fail = (s.fail == LVL_NONE) ? LVL_THIRD : s.fail;
            next_s.page = 1'b0;
          end else if (ent_rsvd || (ent_page && !cfg.gb_en)) begin
            // R14 unsupported page bit
            next_s.misc = 1'b1;
            next_s.fail = LVL_THIRD;
          end else begin
            // R21 violation from any level
            next_s.perm = new_perm;
            next_s.fail = new_fail;
            next_s.viol = (new_fail != LVL_NONE);
            if (ent_page) begin
              // R11 page output address
              next_s.pa = (mem_data_in & GB_MASK) | (s.gpa & GB_OFS);
              // R12 attributes carried along
              next_s.mt = mem_data_in[MT_LO+2:MT_LO];
              next_s.ipat = mem_data_in[IPAT_BIT];
            end else begin
              // R15 directory entry address
              next_s.daddr = nwu_ent_addr(mem_data_in, s.gpa[THIRD_LO-1:DIR_LO]);
              // R17 region handed onward
              next_s.region = s.gpa[GPA_MSB:DIR_LO];
            end
          end
        end
      end
      default: begin
        next_s.st = W_IDLE;
      end
    endcase
    // Ready returns once idle again, so walks may run back to back.
    next_s.ready = (next_s.st == W_IDLE) && cfg.enable;
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign req_ready_out = s.ready;
  assign groot_gp_out = s.gp;
  assign mem_req_out = s.mreq;
  assign mem_addr_out = s.maddr;
  assign res_valid_out = s.rvalid;
  assign res_page_out = s.page;
  assign res_pa_out = s.pa;
  assign res_mtype_out = s.mt;
  assign res_ipat_out = s.ipat;
  assign res_dir_addr_out = s.daddr;
  assign res_region_out = s.region;
  assign res_perm_out = s.perm;
  assign res_viol_out = s.viol;
  assign res_misconf_out = s.misc;
  assign res_pf_out = s.pf;
  assign res_fail_lvl_out = s.fail;
  assign res_levels_out = s.lev;

  // Checks that tie results to the entries and requests that caused them.
  sequence s_take_narrow;
    take && ((req_gpa_in & WIDE_MASK) == '0);
  endsequence
  sequence s_top_fetch;
    mem_req_out && (mem_addr_out == nwu_ent_addr(cfg.root, s.gpa[GPA_MSB:TOP_LO]));
  endsequence

  property p_top_addr;
    @(posedge clk_in) disable iff (!resetn_in) s_take_narrow |=> s_top_fetch;
  endproperty
  a_top_addr: assert property (p_top_addr) else $error("top entry fetch address wrong"); // R04

  property p_wide_pf;
    @(posedge clk_in) disable iff (!resetn_in)
      take && ((req_gpa_in & WIDE_MASK) != '0) |=> res_valid_out && res_pf_out && !mem_req_out;
  endproperty
  a_wide_pf: assert property (p_wide_pf) else $error("wide guest address did not fault"); // R18

  property p_root_gp;
    @(posedge clk_in) disable iff (!resetn_in)
      groot_load_in && ((groot_val_in & WIDE_MASK) != '0) |=> groot_gp_out;
  endproperty
  a_root_gp: assert property (p_root_gp) else $error("wide root load did not fault"); // R18

  property p_np_viol;
    @(posedge clk_in) disable iff (!resetn_in)
      (s.st != W_IDLE) && mem_ack_in && (mem_data_in[PERM_W-1:0] == '0)
      |=> res_valid_out && res_viol_out && !res_misconf_out;
  endproperty
  a_np_viol: assert property (p_np_viol) else $error("absent entry not a violation"); // R19

  property p_top_rsvd;
    @(posedge clk_in) disable iff (!resetn_in)
      (s.st == W_TOP) && mem_ack_in && (mem_data_in[PERM_W-1:0] != '0) && ((mem_data_in & LOW_RSVD) != '0)
      |=> res_valid_out && res_misconf_out && !res_viol_out;
  endproperty
  a_top_rsvd: assert property (p_top_rsvd) else $error("reserved top bits not misconfigured"); // R07

  property p_levels;
    @(posedge clk_in) disable iff (!resetn_in) res_valid_out |-> res_levels_out <= LVL_UPPER_MAX;
  endproperty
  a_levels: assert property (p_levels) else $error("too many entries fetched"); // R02

  property p_page_pa;
    @(posedge clk_in) disable iff (!resetn_in)
      res_valid_out && res_page_out && !res_misconf_out
      |-> ((res_pa_out & ADDR_TOP0) == '0) && ((res_pa_out & GB_OFS) == (s.gpa & GB_OFS));
  endproperty
  a_page_pa: assert property (p_page_pa) else $error("page address malformed"); // R11

  property p_dir_addr;
    @(posedge clk_in) disable iff (!resetn_in)
      res_valid_out && !res_page_out && !res_misconf_out && !res_pf_out && (res_levels_out == LVL_UPPER_MAX)
      && (res_perm_out != '0) |-> res_dir_addr_out[ENT_SH+IDX_W-1:ENT_SH] == s.gpa[THIRD_LO-1:DIR_LO];
  endproperty
  a_dir_addr: assert property (p_dir_addr) else $error("directory entry index wrong"); // R15

  property p_perm;
    @(posedge clk_in) disable iff (!resetn_in)
      res_valid_out && !res_misconf_out && !res_pf_out && ((s.acc & ~res_perm_out) != '0) |-> res_viol_out;
  endproperty
  a_perm: assert property (p_perm) else $error("missing right not a violation"); // R21
endmodule
`default_nettype wire

// *** verif/nwu_mem_model.sv ***
// Behavioural memory system that answers the walker's entry fetches.
`timescale 1ns/1ps
`default_nettype none
module nwu_mem_model (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Fetch port facing the walker.
  input wire logic mem_req_in,
  input wire logic [63:0] mem_addr_in,
  output logic mem_ack_out,
  output logic [63:0] mem_data_out,
  // Scenario control: idle cycles before each answer and the two entries.
  input wire logic [1:0] delay_in,
  input wire logic [63:0] top_ent_in,
  input wire logic [63:0] third_ent_in
);
  logic [1:0] wait_cnt; // Cycles already waited on this fetch.
  logic second; // The next answer is the third-level entry.

  // Answer each fetch after delay_in cycles with one whole entry.
  // Outside an answer the data lines flip every cycle, so stale data never matches.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mem_ack_out <= 1'b0;
      mem_data_out <= 64'h0;
      wait_cnt <= 2'h0;
      second <= 1'b0;
    end else if (mem_ack_out) begin
      mem_ack_out <= 1'b0;
      mem_data_out <= ~mem_data_out;
      wait_cnt <= 2'h0;
    end else if (mem_req_in && wait_cnt == delay_in) begin
      mem_ack_out <= 1'b1;
      mem_data_out <= second ? third_ent_in : top_ent_in;
      second <= 1'b1;
    end else begin
      mem_data_out <= ~mem_data_out;
      wait_cnt <= mem_req_in ? wait_cnt + 2'h1 : 2'h0;
      second <= second & mem_req_in;
    end
  end
endmodule
`default_nettype wire

// *** verif/test_nested_translation_walker_upper.sv ***
// Self-checking testbench of the nested translation upper walker.
`timescale 1ns/1ps
`default_nettype none
module test_nested_translation_walker_upper;
  import nwu_pkg::*;
  // Reserved bits 51:N of every entry, N being 48.
  localparam logic [63:0] HI_RSVD = 64'h000F_0000_0000_0000;
  typedef struct packed {
    logic pf, viol, misc, page, ipat;
    logic [2:0] fail, levels, perm, mt;
    logic [63:0] pa, dir, a0, a1;
    logic [26:0] region;
  } nwu_exp_t;
  logic clk_in, resetn_in, reg_wr_in, reg_rd_in, req_valid_in, groot_load_in;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [63:0] req_gpa_in, groot_val_in, mem_addr_out, mem_data_in, res_pa_out, res_dir_addr_out;
  logic [2:0] req_acc_in, res_mtype_out, res_perm_out, res_fail_lvl_out, res_levels_out;
  logic req_ready_out, groot_gp_out, mem_req_out, mem_ack_in, res_valid_out, res_page_out;
  logic res_ipat_out, res_viol_out, res_misconf_out, res_pf_out;
  logic [26:0] res_region_out;
  logic [1:0] mem_delay;
  logic [63:0] top_ent, third_ent, root, t, d;
  logic [63:0] seen[$]; // Fetch addresses taken by the memory in this walk.
  int errors, checks_done;

  nwu_walker DUT (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .req_valid_in(req_valid_in), .req_gpa_in(req_gpa_in), .req_acc_in(req_acc_in), .req_ready_out(req_ready_out),
    .groot_load_in(groot_load_in), .groot_val_in(groot_val_in), .groot_gp_out(groot_gp_out),
    .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in), .mem_data_in(mem_data_in),
    .res_valid_out(res_valid_out), .res_page_out(res_page_out), .res_pa_out(res_pa_out),
    .res_mtype_out(res_mtype_out), .res_ipat_out(res_ipat_out), .res_dir_addr_out(res_dir_addr_out),
    .res_region_out(res_region_out), .res_perm_out(res_perm_out), .res_viol_out(res_viol_out),
    .res_misconf_out(res_misconf_out), .res_pf_out(res_pf_out), .res_fail_lvl_out(res_fail_lvl_out),
    .res_levels_out(res_levels_out));
  nwu_mem_model mem (.clk_in(clk_in), .resetn_in(resetn_in), .mem_req_in(mem_req_out),
    .mem_addr_in(mem_addr_out), .mem_ack_out(mem_ack_in), .mem_data_out(mem_data_in),
    .delay_in(mem_delay), .top_ent_in(top_ent), .third_ent_in(third_ent));

  // Free-running 200 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Record every fetch address at the edge that consumes it.
  always @(posedge clk_in) begin
    if (mem_ack_in && mem_req_out) seen.push_back(mem_addr_out);
  end

  // Print the counts and the verdict, then stop.
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // One write or read cycle on the register port; read data stand one cycle later.
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk(reg_rdata_out, exp);
  endtask

  // Work out the result of one walk from the entry formats.
  function automatic nwu_exp_t predict(input logic [63:0] g, input logic [2:0] acc, input logic gb);
    nwu_exp_t e;
    e = '0;
    e.a0 = (root & BASE_MASK) | {52'h0, g[47:39], 3'h0};
    if (g[63:48] != 16'h0) begin
      e.pf = 1'b1;
      // No entry is visited, so no right has been withdrawn yet.
      e.perm = 3'h7;
      return e;
    end
    e.levels = 3'h1;
    if (t[2:0] == 3'h0) begin
      e.viol = 1'b1;
      e.fail = LVL_TOP;
      return e;
    end
    if ((t & (LOW_RSVD | HI_RSVD)) != 64'h0) begin
      e.misc = 1'b1;
      return e;
    end
    e.levels = 3'h2;
    e.a1 = (t & BASE_MASK) | {52'h0, g[38:30], 3'h0};
    if (d[2:0] == 3'h0) begin
      e.viol = 1'b1;
      e.fail = ((acc & ~t[2:0]) != 3'h0) ? LVL_TOP : LVL_THIRD;
      return e;
    end
    e.page = d[PS_BIT];
    // reserved third bits outrank a missing right
    if ((d[PS_BIT] ? (!gb || (d & GB_RSVD) != 64'h0) : d[6:3] != 4'h0) || (d & HI_RSVD) != 64'h0) begin
      e.misc = 1'b1;
      return e;
    end
    e.perm = t[2:0] & d[2:0];
    e.pa = (d & GB_MASK) | (g & GB_OFS);
    e.mt = d[5:3];
    e.ipat = d[IPAT_BIT];
    e.dir = (d & BASE_MASK) | {52'h0, g[29:21], 3'h0};
    e.region = g[47:21];
    if ((acc & ~e.perm) != 3'h0) begin
      e.viol = 1'b1;
      e.fail = ((acc & ~t[2:0]) != 3'h0) ? LVL_TOP : LVL_THIRD;
    end
    return e;
  endfunction

  // Run one walk with entries t and d and compare the result fields that its outcome defines.
  task automatic walk(input logic [63:0] g, input logic [2:0] acc, input logic gb);
    nwu_exp_t e;
    int n;
    e = predict(g, acc, gb);
    seen.delete();
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_gpa_in <= g;
    req_acc_in <= acc;
    top_ent <= t;
    third_ent <= d;
    mem_delay <= 2'($urandom_range(3));
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 60);
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (res_valid_out !== 1'b1 && n < 60);
    if (res_valid_out !== 1'b1) begin
      errors++;
      return;
    end
    chk(res_pf_out, e.pf);
    chk(res_misconf_out, e.misc);
    chk(res_viol_out, e.viol);
    chk(res_levels_out, e.levels);
    chk(64'(seen.size()), 64'(e.levels));
    if (seen.size() > 0) chk(seen[0], e.a0);
    if (seen.size() > 1) chk(seen[1], e.a1);
    if (!e.misc) chk(res_fail_lvl_out, e.fail);
    if (!e.misc) chk(res_perm_out, e.perm);
    if (e.misc || e.levels != 3'h2 || d[2:0] == 3'h0) return;
    chk(res_page_out, e.page);
    if (e.page) begin
      chk(res_pa_out, e.pa);
      chk(res_mtype_out, e.mt);
      chk(res_ipat_out, e.ipat);
    end else begin
      chk(res_dir_addr_out, e.dir);
      chk(res_region_out, e.region);
    end
  endtask

  // Random well-formed entries: top, page-mapping third and directory pointer.
  function automatic logic [63:0] ent(input int kind);
    logic [63:0] r;
    r = {$urandom, $urandom} & ~HI_RSVD;
    if (kind == 0) return r & ~LOW_RSVD;
    if (kind == 1) return (r & ~GB_RSVD) | 64'h80;
    return r & ~LOW_RSVD;
  endfunction

  // Main sequence: registers, corner walks, then random walks.
  initial begin
    resetn_in = 1'b0;
    {reg_wr_in, reg_rd_in, req_valid_in, groot_load_in} = 4'h0;
    {reg_addr_in, reg_wdata_in, req_gpa_in, req_acc_in, groot_val_in} = '0;
    {mem_delay, top_ent, third_ent} = '0;
    errors = 0;
    checks_done = 0;
    void'($urandom(32'hAF97BEF8));
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    rreg(REG_CTRL, 32'h3);
    wreg(8'h14, 32'hFFFF_FFFF);
    rreg(8'h14, 32'h0);
    root = {$urandom, $urandom};
    wreg(REG_ROOT_LO, root[31:0]);
    wreg(REG_ROOT_HI, root[63:32]);
    // guest root load check, wide and narrow.
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in);
      groot_load_in <= 1'b1;
      groot_val_in <= i ? 64'h0000_FFFF_FFFF_F000 : 64'h0001_0000_0000_0000;
      @(posedge clk_in);
      groot_load_in <= 1'b0;
      @(negedge clk_in);
      chk(groot_gp_out, 64'(i == 0));
    end
    t = ent(0) | 64'h7;
    d = ent(1) | 64'h7;
    walk(64'h0001_0000_0000_0000, 3'h1, 1'b1);
    walk(64'h0000_FFFF_FFFF_FFFF, 3'h7, 1'b1);
    t = t | 64'h80;
    walk(64'h0000_0012_3456_7890, 3'h1, 1'b1);
    t = (t & ~64'h80) | 64'h0001_0000_0000_0000;
    walk(64'h0000_0012_3456_7890, 3'h1, 1'b1);
    t = (t & ~HI_RSVD) & ~64'h7;
    walk(64'h0000_0012_3456_7890, 3'h4, 1'b1);
    t = t | 64'h2;
    d = d | 64'h1000;
    walk(64'h0000_8000_4000_0000, 3'h1, 1'b1);
    t = t | 64'h7;
    d = ent(2) | 64'h8;
    walk(64'h0000_8000_4000_0000, 3'h1, 1'b1);
    d = ent(2) | 64'h1;
    walk(64'h0000_7FFF_FFE0_0000, 3'h2, 1'b1);
    // software has withdrawn 1-GByte page support.
    wreg(REG_CTRL, 32'h1);
    d = ent(1) | 64'h7;
    walk(64'h0000_0000_4000_0000, 3'h1, 1'b0);
    rreg(REG_STATUS, 32'h0000_0304);
    wreg(REG_CTRL, 32'h3);
    for (int i = 0; i < 60; i++) begin
      t = ent(0);
      d = ent($urandom_range(1, 2));
      if ($urandom_range(9) == 0) t = t | 64'h8;
      walk({16'h0, 16'($urandom), $urandom}, 3'($urandom_range(1, 7)), 1'b1);
    end
    complete_run();
  end
endmodule
`default_nettype wire
